/* flash_seq.sv */
// Serial flash command sequencer with AHB-Lite protection and status registers
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "flash_seq_cfg.svh"
module flash_seq #(
  parameter logic [31:0] SECTOR_ERASE_CYCLES = `MS_TO_CYC(`SECTOR_ERASE_TIME_MS),
  parameter logic [31:0] BLOCK_ERASE_CYCLES  = `MS_TO_CYC(`BLOCK_ERASE_TIME_MS),
  parameter logic [31:0] CHIP_ERASE_CYCLES   = `MS_TO_CYC(`CHIP_ERASE_TIME_MS)
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sclk,
  input  wire logic        chip_select_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe
);

  localparam logic [31:0] BYTE_PROG_CYCLES = `US_TO_CYC(`BYTE_PROGRAM_TIME_US);

  flash_seq_pkg::link_ev_t ev;
  flash_seq_pkg::phase_t   phase_q;
  flash_seq_pkg::status_t  stat;
  logic [7:0]              opc_q;
  logic [2:0]              bit_q;
  logic [6:0]              in_sh_q;
  logic [15:0]             addr_sh_q;
  logic [1:0]              nbyte_q;
  logic [18:0]             cmd_addr_q;
  logic [7:0]              dat_q;
  logic                    cmd_ok_q;
  logic [18:0]             rd_ptr_q;
  logic [7:0]              out_sh_q;
  logic                    miso_q;
  logic                    miso_oe_q;
  logic                    wel_q;
  logic                    aai_q;
  logic [18:0]             aai_addr_q;
  logic [19:0]             prot_base_q;
  logic                    er_act_q;
  logic [18:0]             er_ptr_q;
  logic [18:0]             er_end_q;
  logic                    wr_pend_q;
  logic [7:0]              wr_addr_q;
  logic [31:0]             hrdata_q;
  logic                    hreadyout_q;
  logic                    hresp_q;
  logic [7:0]              mem [0:`ARRAY_BYTES-1];

  logic                    byte_done;
  logic [7:0]              rx;
  logic [18:0]             new_addr;
  logic                    busy;
  logic                    exec;
  logic                    load_rd;
  logic                    load_st;
  logic [18:0]             rd_idx;
  logic [18:0]             wr_addr;
  logic                    aai_last;
  logic                    prog_we;
  logic                    tmr_start;
  logic [31:0]             tmr_cyc;
  logic                    tmr_busy;
  logic                    er_start;
  logic [18:0]             er_lo;
  logic [18:0]             er_hi;

  function automatic logic prot_hit(input logic [18:0] a, input logic [19:0] base);
    prot_hit = ({1'b0, a} >= base);
  endfunction

  link_sync u_sync (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .sclk          (sclk),
    .chip_select_n (chip_select_n),
    .mosi          (mosi),
    .ev            (ev)
  );

  busy_timer u_tmr (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (tmr_start),
    .cycles  (tmr_cyc),
    .busy    (tmr_busy)
  );

  assign byte_done = ev.sclk_rise & ev.cs_low & (bit_q == 3'h7);
  assign rx        = {in_sh_q, ev.mosi};
  assign new_addr  = {addr_sh_q[10:0], rx};
  assign busy      = tmr_busy | er_act_q;
  assign exec      = ev.cs_rise & cmd_ok_q;

  always_comb begin
    stat       = '0;
    stat.busy  = busy;
    stat.write_enable_latch   = wel_q;
    stat.auto_increment_program   = aai_q;
  end

  // Serial bit counter and input shifter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_q   <= 3'h0;
      in_sh_q <= 7'h0;
    end else if (!ev.cs_low) begin
      bit_q <= 3'h0;
    end else if (ev.sclk_rise) begin
      bit_q   <= bit_q + 3'h1;
      in_sh_q <= rx[6:0];
    end
  end

  // Command phase sequencing; busy blocks all but status read and disable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q    <= flash_seq_pkg::ST_OPCODE;
      opc_q      <= 8'h0;
      addr_sh_q  <= 16'h0;
      nbyte_q    <= 2'h0;
      cmd_addr_q <= 19'h0;
      dat_q      <= 8'h0;
      cmd_ok_q   <= 1'b0;
    end else if (!ev.cs_low) begin
      phase_q  <= flash_seq_pkg::ST_OPCODE;
      nbyte_q  <= 2'h0;
      cmd_ok_q <= 1'b0;
    end else if (byte_done) begin
      case (phase_q)
        flash_seq_pkg::ST_OPCODE: begin
          opc_q <= rx;
          case (rx)
            flash_seq_pkg::OPC_STAT: phase_q <= flash_seq_pkg::ST_STREAM;
            flash_seq_pkg::OPC_WRITE_DISABLE_COMMAND: begin
              phase_q  <= flash_seq_pkg::ST_DONE;
              cmd_ok_q <= 1'b1;
            end
            flash_seq_pkg::OPC_WRITE_ENABLE_COMMAND, flash_seq_pkg::OPC_CHIP: begin
              phase_q  <= flash_seq_pkg::ST_DONE;
              cmd_ok_q <= ~busy;
            end
            flash_seq_pkg::OPC_READ, flash_seq_pkg::OPC_FAST, flash_seq_pkg::OPC_PROG,
            flash_seq_pkg::OPC_SECT, flash_seq_pkg::OPC_BLOCK: begin
              phase_q <= busy ? flash_seq_pkg::ST_DONE : flash_seq_pkg::ST_ADDR;
            end
            flash_seq_pkg::OPC_AAI: begin
              if (busy) begin
                phase_q <= flash_seq_pkg::ST_DONE;
              end else begin
                phase_q <= aai_q ? flash_seq_pkg::ST_DATA_IN : flash_seq_pkg::ST_ADDR;
              end
            end
            default: phase_q <= flash_seq_pkg::ST_DONE;
          endcase
        end
        flash_seq_pkg::ST_ADDR: begin
          addr_sh_q <= {addr_sh_q[7:0], rx};
          nbyte_q   <= nbyte_q + 2'h1;
          if (nbyte_q == 2'h2) begin
            cmd_addr_q <= new_addr;
            case (opc_q)
              flash_seq_pkg::OPC_READ: phase_q <= flash_seq_pkg::ST_STREAM;
              flash_seq_pkg::OPC_FAST: phase_q <= flash_seq_pkg::ST_DUMMY;
              flash_seq_pkg::OPC_PROG, flash_seq_pkg::OPC_AAI: begin
                phase_q <= flash_seq_pkg::ST_DATA_IN;
              end
              flash_seq_pkg::OPC_SECT, flash_seq_pkg::OPC_BLOCK: begin
                phase_q  <= flash_seq_pkg::ST_DONE;
                cmd_ok_q <= 1'b1;
              end
              default: phase_q <= flash_seq_pkg::ST_DONE;
            endcase
          end
        end
        flash_seq_pkg::ST_DUMMY: phase_q <= flash_seq_pkg::ST_STREAM;
        flash_seq_pkg::ST_DATA_IN: begin
          dat_q    <= rx;
          phase_q  <= flash_seq_pkg::ST_DONE;
          cmd_ok_q <= 1'b1;
        end
        default: phase_q <= phase_q;
      endcase
    end
  end

  // Output stream: load at byte end on a rise, shift on each fall
  assign load_rd = ((phase_q == flash_seq_pkg::ST_ADDR) && (nbyte_q == 2'h2)
                    && (opc_q == flash_seq_pkg::OPC_READ))
                   || (phase_q == flash_seq_pkg::ST_DUMMY)
                   || ((phase_q == flash_seq_pkg::ST_STREAM) && (opc_q != flash_seq_pkg::OPC_STAT));
  assign load_st = ((phase_q == flash_seq_pkg::ST_OPCODE) && (rx == flash_seq_pkg::OPC_STAT))
                   || ((phase_q == flash_seq_pkg::ST_STREAM) && (opc_q == flash_seq_pkg::OPC_STAT));
  // Fast read starts from the latched address once the dummy byte ends
  assign rd_idx  = (phase_q == flash_seq_pkg::ST_ADDR)  ? new_addr :
                   (phase_q == flash_seq_pkg::ST_DUMMY) ? cmd_addr_q : rd_ptr_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ptr_q  <= 19'h0;
      out_sh_q  <= 8'h0;
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;
    end else if (!ev.cs_low) begin
      miso_oe_q <= 1'b0;
    end else if (byte_done && load_rd) begin
      out_sh_q <= mem[rd_idx];
      rd_ptr_q <= rd_idx + 19'h1;
    end else if (byte_done && load_st) begin
      out_sh_q <= stat;
    end else if (ev.sclk_fall && (phase_q == flash_seq_pkg::ST_STREAM)) begin
      miso_q    <= out_sh_q[7];
      out_sh_q  <= {out_sh_q[6:0], 1'b1};
      miso_oe_q <= 1'b1;
    end
  end

  // Execution at deselect; the latch gates every write
  assign wr_addr  = (opc_q == flash_seq_pkg::OPC_AAI && aai_q) ? aai_addr_q : cmd_addr_q;
  assign aai_last = (wr_addr == `ARRAY_TOP) || (({1'b0, wr_addr} + 20'h1) == prot_base_q);

  always_comb begin
    prog_we   = 1'b0;
    tmr_start = 1'b0;
    tmr_cyc   = BYTE_PROG_CYCLES;
    er_start  = 1'b0;
    er_lo     = 19'h0;
    er_hi     = `ARRAY_TOP;
    if (exec && wel_q) begin
      case (opc_q)
        flash_seq_pkg::OPC_PROG, flash_seq_pkg::OPC_AAI: begin
          prog_we   = ~prot_hit(wr_addr, prot_base_q);
          tmr_start = prog_we;
        end
        flash_seq_pkg::OPC_SECT: begin
          er_lo     = cmd_addr_q & ~`SECTOR_MASK;
          er_hi     = cmd_addr_q | `SECTOR_MASK;
          er_start  = ~prot_hit(er_hi, prot_base_q);
          tmr_start = er_start;
          tmr_cyc   = SECTOR_ERASE_CYCLES;
        end
        flash_seq_pkg::OPC_BLOCK: begin
          er_lo     = cmd_addr_q & ~`BLOCK_MASK;
          er_hi     = cmd_addr_q | `BLOCK_MASK;
          er_start  = ~prot_hit(er_hi, prot_base_q);
          tmr_start = er_start;
          tmr_cyc   = BLOCK_ERASE_CYCLES;
        end
        flash_seq_pkg::OPC_CHIP: begin
          er_start  = (prot_base_q == `REG_PROT_RST);
          tmr_start = er_start;
          tmr_cyc   = CHIP_ERASE_CYCLES;
        end
        default: prog_we = 1'b0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wel_q      <= 1'b0;
      aai_q      <= 1'b0;
      aai_addr_q <= 19'h0;
    end else if (exec) begin
      if (opc_q == flash_seq_pkg::OPC_WRITE_ENABLE_COMMAND) begin
        wel_q <= 1'b1;
      end else if (opc_q == flash_seq_pkg::OPC_WRITE_DISABLE_COMMAND) begin
        wel_q <= 1'b0;
        aai_q <= 1'b0;
      end else if (opc_q == flash_seq_pkg::OPC_AAI) begin
        if (prog_we) begin
          aai_q      <= ~aai_last;
          wel_q      <= ~aai_last;
          aai_addr_q <= wr_addr + 19'h1;
        end
      end else if (tmr_start) begin
        wel_q <= 1'b0;
      end
    end
  end

  // Erase walk; also clears the array after reset, shown as busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      er_act_q <= 1'b1;
      er_ptr_q <= 19'h0;
      er_end_q <= `ARRAY_TOP;
    end else if (er_start) begin
      er_act_q <= 1'b1;
      er_ptr_q <= er_lo;
      er_end_q <= er_hi;
    end else if (er_act_q) begin
      er_act_q <= (er_ptr_q != er_end_q);
      er_ptr_q <= er_ptr_q + 19'h1;
    end
  end

  // Array has no reset; program can only clear bits
  always_ff @(posedge hclk) begin
    if (prog_we) begin
      mem[wr_addr] <= mem[wr_addr] & dat_q;
    end else if (er_act_q) begin
      mem[er_ptr_q] <= `ERASED_BYTE;
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h0;
      hrdata_q    <= 32'h0;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      prot_base_q <= `REG_PROT_RST;
    end else begin
      wr_pend_q <= hsel & hready & htrans[1] & hwrite;
      if (hsel && hready && htrans[1]) begin
        wr_addr_q <= haddr[`REG_ADDR_MSB:0];
        if (!hwrite) begin
          case (haddr[`REG_ADDR_MSB:0])
            `REG_STATUS_OFS: hrdata_q <= {24'h0, stat};
            `REG_PROT_OFS:   hrdata_q <= {12'h0, prot_base_q};
            default:         hrdata_q <= 32'h0;
          endcase
        end
      end
      if (wr_pend_q && (wr_addr_q == `REG_PROT_OFS)) begin
        prot_base_q <= hwdata[19:0];
      end
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign miso      = miso_q;
  assign miso_oe   = miso_oe_q;

  a_write_enable_command_sets_wel: assert property (@(posedge hclk) disable iff (!hresetn)
    exec && (opc_q == flash_seq_pkg::OPC_WRITE_ENABLE_COMMAND) |=> wel_q)
    else $error("write enable did not set latch");
  a_write_disable_command_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    exec && (opc_q == flash_seq_pkg::OPC_WRITE_DISABLE_COMMAND) |=> !wel_q && !aai_q)
    else $error("write disable did not clear latch and mode");
  a_busy_at_deselect: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(busy) |-> $past(ev.cs_rise))
    else $error("busy rose without deselect");
  a_prot_prog_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    exec && (opc_q == flash_seq_pkg::OPC_PROG) && prot_hit(cmd_addr_q, prot_base_q)
    |=> !busy [*2])
    else $error("protected program started");
  a_read_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    byte_done && load_rd && (rd_idx == `ARRAY_TOP) |=> (rd_ptr_q == 19'h0))
    else $error("read pointer did not wrap");
  a_dummy_silent: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_q == flash_seq_pkg::ST_DUMMY) |-> !miso_oe_q)
    else $error("output driven during dummy byte");
  a_status_repeat: assert property (@(posedge hclk) disable iff (!hresetn)
    byte_done && (phase_q == flash_seq_pkg::ST_STREAM) && (opc_q == flash_seq_pkg::OPC_STAT)
    |=> (out_sh_q == $past(stat)))
    else $error("status byte not reloaded");
  a_aai_top_exit: assert property (@(posedge hclk) disable iff (!hresetn)
    exec && (opc_q == flash_seq_pkg::OPC_AAI) && prog_we && aai_last |=> !aai_q && !wel_q)
    else $error("auto increment did not stop at top");
  a_aai_prot_ignore: assert property (@(posedge hclk) disable iff (!hresetn)
    exec && (opc_q == flash_seq_pkg::OPC_AAI) && !aai_q && prot_hit(cmd_addr_q, prot_base_q)
    |=> !aai_q)
    else $error("protected auto increment entered");
  a_chip_prot: assert property (@(posedge hclk) disable iff (!hresetn)
    exec && (opc_q == flash_seq_pkg::OPC_CHIP) && (prot_base_q != `REG_PROT_RST)
    |=> !er_act_q ##1 !er_act_q)
    else $error("chip erase ran with protection");

endmodule

/* flash_seq_cfg.svh */
// Offsets, reset values, field masks and timing counts of the flash sequencer
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH

`define REG_STATUS_OFS 8'h00
`define REG_PROT_OFS 8'h04
`define REG_PROT_RST 20'h80000
`define REG_ADDR_MSB 7

`define TOP_ADDRESS_BIT 18
`define ARRAY_BYTES 524288
`define ARRAY_TOP 19'h7ffff
`define SECTOR_MASK 19'h00fff
`define BLOCK_MASK 19'h07fff
`define ERASED_BYTE 8'hff

`define CLK_PERIOD_NS 25
`define BYTE_PROGRAM_TIME_US 14
`define SECTOR_ERASE_TIME_MS 18
`define BLOCK_ERASE_TIME_MS 18
`define CHIP_ERASE_TIME_MS 70
`define NS_TO_CYC(t) ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define US_TO_CYC(t) (`NS_TO_CYC((t) * 1000))
`define MS_TO_CYC(t) (`NS_TO_CYC((t) * 1000000))

`endif

/* flash_seq_pkg.sv */
// Types shared by the flash sequencer modules
package flash_seq_pkg;

  typedef enum logic [7:0] {
    OPC_READ  = 8'h03,
    OPC_FAST  = 8'h0b,
    OPC_PROG  = 8'h02,
    OPC_AAI   = 8'haf,
    OPC_SECT  = 8'h20,
    OPC_BLOCK = 8'h52,
    OPC_CHIP  = 8'h60,
    OPC_WRITE_ENABLE_COMMAND  = 8'h06,
    OPC_WRITE_DISABLE_COMMAND  = 8'h04,
    OPC_STAT  = 8'h05
  } opcode_t;

  typedef enum logic [2:0] {
    ST_OPCODE  = 3'b000,
    ST_ADDR    = 3'b001,
    ST_DUMMY   = 3'b010,
    ST_DATA_IN = 3'b011,
    ST_STREAM  = 3'b100,
    ST_DONE    = 3'b101
  } phase_t;

  typedef struct packed {
    logic       rsvd7;
    logic       auto_increment_program;
    logic [3:0] rsvd;
    logic       write_enable_latch;
    logic       busy;
  } status_t;

  typedef struct packed {
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic cs_low;
    logic mosi;
  } link_ev_t;

endpackage

/* link_sync.sv */
// Two-flop synchronisers and edge detection for the serial link pins
`timescale 1ns/1ps
module link_sync (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     sclk,
  input  wire logic                     chip_select_n,
  input  wire logic                     mosi,
  output flash_seq_pkg::link_ev_t       ev
);

  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] prev_q;

  // Deselected idle state at reset so no false edge appears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= 3'h2;
      sync_q <= 3'h2;
      prev_q <= 3'h2;
    end else begin
      meta_q <= {mosi, chip_select_n, sclk};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Only the second stage and its delayed copy feed logic
  assign ev.sclk_rise = sync_q[0] & ~prev_q[0];
  assign ev.sclk_fall = ~sync_q[0] & prev_q[0];
  assign ev.cs_rise   = sync_q[1] & ~prev_q[1];
  assign ev.cs_low    = ~sync_q[1];
  assign ev.mosi      = sync_q[2];

endmodule

/* busy_timer.sv */
// Self-timed operation counter for program and erase
`timescale 1ns/1ps
module busy_timer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        start,
  input  wire logic [31:0] cycles,
  output logic             busy
);

  logic [31:0] cnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 32'h0;
    end else if (start) begin
      cnt_q <= cycles;
    end else if (cnt_q != 32'h0) begin
      cnt_q <= cnt_q - 32'h1;
    end
  end

  assign busy = (cnt_q != 32'h0);

endmodule

/* spi_host_model.sv */
// Behavioural SPI host that frames commands towards the flash sequencer
`timescale 1ns/1ps
module spi_host_model (
  output logic      sclk,
  output logic      chip_select_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic sel();
    chip_select_n = 1'b0;
    #100;
  endtask
  // Mode 0 at 5 MHz, well under the normal read limit
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      mosi = d[i];
      #100 sclk = 1'b1;
      #99 q[i] = miso;
      #1 sclk = 1'b0;
    end
  endtask
  // Released line toggles so a stale bit never reads as data
  task automatic desel();
    #100 chip_select_n = 1'b1;
    mosi = ~mosi;
    #400;
  endtask
endmodule

/* tb.sv */
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
module tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sclk;
  logic        chip_select_n;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  int          err_count;
  int          n_checks;
  int          seed;
  logic [7:0]  mem [logic [18:0]];
  logic [31:0] rd;
  logic [7:0]  q;
  logic [23:0] a;
  logic [7:0]  d;
  // Undriven output shows a moving pattern, not a settled level
  wire         miso_line = miso_oe ? miso : hclk;

  flash_seq #(
    .SECTOR_ERASE_CYCLES(32'h10),
    .BLOCK_ERASE_CYCLES (32'h10),
    .CHIP_ERASE_CYCLES  (32'h10)
  ) i_flash_seq (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hreadyout),
    .hrdata       (hrdata),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .sclk         (sclk),
    .chip_select_n(chip_select_n),
    .mosi         (mosi),
    .miso         (miso),
    .miso_oe      (miso_oe)
  );
  spi_host_model i_spi_host_model (
    .sclk         (sclk),
    .chip_select_n(chip_select_n),
    .mosi         (mosi),
    .miso         (miso_line)
  );

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  function automatic logic [7:0] stx(input logic auto_increment_program, input logic write_enable_latch, input logic busy);
    return {1'b0, auto_increment_program, 4'h0, write_enable_latch, busy};
  endfunction
  function automatic logic [7:0] mx(input logic [23:0] ad);
    return mem.exists(ad[18:0]) ? mem[ad[18:0]] : 8'hff;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge hclk);
    htrans <= 2'b10;
    haddr <= {24'h0, ad};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 100);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  // Polling, not a fixed wait: busy length depends on the operation
  task automatic idle();
    int n;
    n = 0;
    do ahb(1'b0, 8'h00, 32'h0); while (rd[0] !== 1'b0 && ++n < 300000);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] ad, input int na);
    i_spi_host_model.sel();
    i_spi_host_model.xbyte(op, q);
    for (int i = 2; i >= 3 - na; i--) i_spi_host_model.xbyte(ad[i*8 +: 8], q);
  endtask
  task automatic op1(input logic [7:0] op);
    cmd(op, 24'h0, 0);
    i_spi_host_model.desel();
  endtask
  task automatic prog(input logic [7:0] op, input logic [23:0] ad, input int na,
                      input logic [7:0] dd);
    cmd(op, ad, na);
    i_spi_host_model.xbyte(dd, q);
    i_spi_host_model.desel();
  endtask
  task automatic stat(input logic [7:0] e);
    logic [7:0] s;
    cmd(flash_seq_pkg::OPC_STAT, 24'h0, 0);
    repeat (2) begin
      i_spi_host_model.xbyte(8'($random(seed)), s);
      chk({24'h0, s}, {24'h0, e});
    end
    i_spi_host_model.desel();
  endtask
  task automatic rdchk(input logic [7:0] op, input logic [23:0] ad);
    logic [7:0] s;
    cmd(op, ad, 3);
    if (op == 8'h0b) i_spi_host_model.xbyte(8'($random(seed)), s);
    for (int i = 0; i < 3; i++) begin
      i_spi_host_model.xbyte(8'($random(seed)), s);
      chk({24'h0, s}, {24'h0, mx(24'(ad + i))});
    end
    i_spi_host_model.desel();
    chk({31'h0, miso_oe}, 32'h0);
  endtask
  task automatic erase(input logic [7:0] op, input logic [23:0] ad, input logic [18:0] m);
    op1(flash_seq_pkg::OPC_WRITE_ENABLE_COMMAND);
    cmd(op, ad, 3);
    i_spi_host_model.desel();
    foreach (mem[k]) begin
      if ((k | m) == (ad[18:0] | m)) mem[k] = 8'hff;
    end
    idle();
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #40000000;
    err_count++;
    print_verdict();
  end

  initial begin
    seed = 15;
    hresetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    ahb(1'b1, 8'h00, 32'hffffffff);
    ahb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    ahb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h80000);
    ahb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    stat(8'h01);
    idle();
    $display("test registers done");
    op1(flash_seq_pkg::OPC_WRITE_ENABLE_COMMAND);
    stat(stx(1'b0, 1'b1, 1'b0));
    op1(flash_seq_pkg::OPC_WRITE_DISABLE_COMMAND);
    stat(stx(1'b0, 1'b0, 1'b0));
    prog(flash_seq_pkg::OPC_PROG, 24'h001234, 3, 8'h00);
    stat(8'h00);
    rdchk(flash_seq_pkg::OPC_READ, 24'h001234);
    $display("test latch done");
    for (int k = 0; k < 4; k++) begin
      a = 24'($random(seed));
      d = 8'($random(seed));
      if (k == 0) a = 24'hf7ffff;
      op1(flash_seq_pkg::OPC_WRITE_ENABLE_COMMAND);
      prog(flash_seq_pkg::OPC_PROG, a, 3, d);
      stat(stx(1'b0, 1'b0, 1'b1));
      mem[a[18:0]] = mx(a) & d;
      idle();
      rdchk(k[0] ? flash_seq_pkg::OPC_FAST : flash_seq_pkg::OPC_READ, a);
    end
    $display("test program done");
    op1(flash_seq_pkg::OPC_WRITE_ENABLE_COMMAND);
    prog(flash_seq_pkg::OPC_AAI, 24'h010100, 3, 8'h5a);
    idle();
    stat(stx(1'b1, 1'b1, 1'b0));
    prog(flash_seq_pkg::OPC_AAI, 24'h0, 0, 8'ha5);
    idle();
    op1(flash_seq_pkg::OPC_WRITE_DISABLE_COMMAND);
    stat(8'h00);
    mem[19'h10100] = 8'h5a;
    mem[19'h10101] = 8'ha5;
    rdchk(flash_seq_pkg::OPC_READ, 24'h0100ff);
    $display("test auto increment done");
    ahb(1'b1, 8'h04, 32'h40000);
    ahb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h40000);
    op1(flash_seq_pkg::OPC_WRITE_ENABLE_COMMAND);
    prog(flash_seq_pkg::OPC_PROG, 24'h050000, 3, 8'h00);
    op1(flash_seq_pkg::OPC_WRITE_ENABLE_COMMAND);
    prog(flash_seq_pkg::OPC_AAI, 24'h060000, 3, 8'h00);
    op1(flash_seq_pkg::OPC_WRITE_ENABLE_COMMAND);
    op1(flash_seq_pkg::OPC_CHIP);
    op1(flash_seq_pkg::OPC_WRITE_ENABLE_COMMAND);
    op1(flash_seq_pkg::OPC_WRITE_DISABLE_COMMAND);
    idle();
    rdchk(flash_seq_pkg::OPC_READ, 24'h05ffff);
    rdchk(flash_seq_pkg::OPC_READ, 24'h0100ff);
    op1(flash_seq_pkg::OPC_WRITE_ENABLE_COMMAND);
    prog(flash_seq_pkg::OPC_AAI, 24'h03ffff, 3, 8'h3c);
    mem[19'h3ffff] = 8'h3c;
    idle();
    stat(8'h00);
    ahb(1'b1, 8'h04, 32'h80000);
    $display("test protection done");
    erase(flash_seq_pkg::OPC_SECT, 24'h07f000, 19'h00fff);
    erase(flash_seq_pkg::OPC_BLOCK, 24'h012345, 19'h07fff);
    rdchk(flash_seq_pkg::OPC_READ, 24'h07fffe);
    rdchk(flash_seq_pkg::OPC_FAST, 24'h0100ff);
    rdchk(flash_seq_pkg::OPC_READ, 24'h03fffe);
    $display("test erase done");
    print_verdict();
  end
endmodule
